// File: rtl/ptt_pkg.sv
/*
  Constants for the periodic tick timebase: register map, field layout,
  reset values and the rate-select to chain-tap decode.
  Assumes a 32-bit AHB-Lite bus and a slow crystal clock seen as a pin.
*/
package ptt_pkg;

  // clocks
  localparam int unsigned HCLK_HZ = 20_000_000;
  localparam int unsigned XTAL_HZ = 32_768;
  // crystal must be far slower than hclk for edge sampling to work
  localparam int unsigned XTAL_OVERSAMPLE = HCLK_HZ / XTAL_HZ;

  // divider chain
  localparam int unsigned CHAIN_W = 15;
  localparam int unsigned RATE_W  = 3;
  localparam int unsigned TAP_W   = 4;

  // register map, byte addresses on the bus
  localparam int unsigned       ADDR_W      = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] CONF_OFFSET = 8'h04;

  // timebase_control fields
  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned RATE_LSB = 4;
  localparam int unsigned ACK_BIT  = 3;
  localparam int unsigned IEN_BIT  = 2;
  localparam int unsigned RUN_BIT  = 1;

  // timebase_config fields
  localparam int unsigned OSC_STOP_BIT = 0;

  // reset values
  localparam logic [7:0]        CTRL_RESET = 8'h00;
  localparam logic [7:0]        CONF_RESET = 8'h00;
  localparam logic [RATE_W-1:0] RATE_RESET = 3'h0;

  // chain bit whose rising edge marks a tick; bit k repeats every 2^(k+1)
  localparam logic [TAP_W-1:0] TAP_DIV32768 = 4'hE;
  localparam logic [TAP_W-1:0] TAP_DIV8192  = 4'hC;
  localparam logic [TAP_W-1:0] TAP_DIV2048  = 4'hA;
  localparam logic [TAP_W-1:0] TAP_DIV128   = 4'h6;
  localparam logic [TAP_W-1:0] TAP_DIV64    = 4'h5;
  localparam logic [TAP_W-1:0] TAP_DIV32    = 4'h4;
  localparam logic [TAP_W-1:0] TAP_DIV16    = 4'h3;
  localparam logic [TAP_W-1:0] TAP_DIV8     = 4'h2;

  function automatic logic [TAP_W-1:0] tap_index(
    input logic [RATE_W-1:0] rate
  );
    logic [TAP_W-1:0] idx;
    idx = TAP_DIV32768;
    case (rate)
      3'h0:    idx = TAP_DIV32768;
      3'h1:    idx = TAP_DIV8192;
      3'h2:    idx = TAP_DIV2048;
      3'h3:    idx = TAP_DIV128;
      3'h4:    idx = TAP_DIV64;
      3'h5:    idx = TAP_DIV32;
      3'h6:    idx = TAP_DIV16;
      default: idx = TAP_DIV8;
    endcase
    return idx;
  endfunction

endpackage

// File: rtl/ptt_timebase.sv
/*
  Periodic tick timebase with its AHB-Lite register slave.
  Assumes hclk far faster than the crystal, wait_mode and stop_mode
  driven from logic on hclk, crystal_clock arriving unsynchronised.
*/
// Overview of operation
// - fifteen-stage chain counts crystal edges; eight stages selectable as tap.
// - run bit clear holds chain at zero; counting starts when set.
// - overflow at selected tap sets the read-only pending flag.
// - interrupt request while pending flag and irq enable both set.
// - first tick after half a period, later ticks every full period.
// - rate codes 0..7 divide by 32768,8192,2048,128,64,32,16,8.
// - writing one to acknowledge clears the flag; zero ignored; reads zero.
// - reset clears irq enable.
// - reset clears run; stop then run restarts the chain from zero.
// - wait mode keeps counting; registers inaccessible meanwhile.
// - in stop mode the chain runs only with oscillator-in-stop enable.
// - otherwise stop freezes the timebase; registers inaccessible in stop.
// - divider ratios assume a 32.768 kHz crystal, 1 Hz to 4096 Hz.
`timescale 1ns/100ps

module ptt_timebase
  import ptt_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // crystal and power state
  input  wire logic        crystal_clock,
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  // requests to the processor
  output logic             tick_irq,
  output logic             stop_wakeup
);

  // crystal synchroniser and edge detect
  logic                xtal_s1_q;
  logic                xtal_s2_q;
  logic                xtal_s3_q;
  wire logic           xtal_rise;

  // bus data phase
  logic                dph_valid_q;
  logic                dph_write_q;
  logic [ADDR_W-1:0]   dph_addr_q;
  wire logic           addr_phase;
  wire logic           reg_locked;
  wire logic           wr_ok;
  wire logic           wr_ctrl;
  wire logic           wr_conf;
  wire logic           rd_ok;
  wire logic           rd_ctrl;
  wire logic           rd_conf;

  // control state
  logic                run_q;
  logic                run_d;
  logic                ien_q;
  logic                ien_d;
  logic [RATE_W-1:0]   rate_q;
  logic [RATE_W-1:0]   rate_d;
  logic                osc_stop_q;
  logic                osc_stop_d;
  logic                flag_q;
  logic                flag_d;
  wire logic           ack_clear;

  // divider chain
  logic [CHAIN_W-1:0]  chain_q;
  logic [CHAIN_W-1:0]  chain_d;
  logic                tap_prev_q;
  wire logic [TAP_W-1:0] tap_sel;
  wire logic           tap_now;
  wire logic           chain_active;
  wire logic           tick;

  // read data and outputs
  wire logic [7:0]     ctrl_image;
  wire logic [7:0]     conf_image;
  wire logic [31:0]    ctrl_word;
  wire logic [31:0]    conf_word;
  logic [31:0]         rdata_d;
  logic [31:0]         rdata_q;
  logic                irq_q;
  logic                wake_q;
  logic                readyout_q;
  logic                resp_q;

  // write data fields of timebase_control and timebase_config
  wire logic           wr_run;
  wire logic           wr_ien;
  wire logic [RATE_W-1:0] wr_rate;
  wire logic           wr_ack;
  wire logic           wr_osc;

  // offset match, shared by the write and read decode
  function automatic logic addr_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offset
  );
    return addr == offset;
  endfunction

  // crystal edges, first flop read only by the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xtal_s1_q <= 1'b0;
    end else begin
      xtal_s1_q <= crystal_clock;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xtal_s2_q <= 1'b0;
    end else begin
      xtal_s2_q <= xtal_s1_q;
    end
  end

  // resets low like an idle crystal, so no false edge after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xtal_s3_q <= 1'b0;
    end else begin
      xtal_s3_q <= xtal_s2_q;
    end
  end

  assign xtal_rise = xtal_s2_q & ~xtal_s3_q;

  // bus decode; no wait states, so every transfer is taken at once
  assign addr_phase = hsel & hready & htrans[1];
  // the core cannot reach the register while waiting or stopped
  assign reg_locked = wait_mode | stop_mode;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_valid_q <= 1'b0;
    end else begin
      dph_valid_q <= addr_phase;
    end
  end

  // direction and address taken every cycle; only valid qualifies them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_write_q <= 1'b0;
    end else begin
      dph_write_q <= hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_addr_q <= '0;
    end else begin
      dph_addr_q <= haddr[ADDR_W-1:0];
    end
  end

  assign wr_ok   = dph_valid_q & dph_write_q & ~reg_locked;
  assign wr_ctrl = wr_ok & addr_hit(dph_addr_q, CTRL_OFFSET);
  assign wr_conf = wr_ok & addr_hit(dph_addr_q, CONF_OFFSET);
  assign rd_ok   = addr_phase & ~hwrite & ~reg_locked;
  assign rd_ctrl = rd_ok & addr_hit(haddr[ADDR_W-1:0], CTRL_OFFSET);
  assign rd_conf = rd_ok & addr_hit(haddr[ADDR_W-1:0], CONF_OFFSET);

  // write data fields; upper bytes of hwdata are ignored
  assign wr_run  = hwdata[RUN_BIT];
  assign wr_ien  = hwdata[IEN_BIT];
  assign wr_rate = hwdata[RATE_LSB +: RATE_W];
  assign wr_ack  = hwdata[ACK_BIT];
  assign wr_osc  = hwdata[OSC_STOP_BIT];

  // register writes land at the end of the data phase
  assign run_d      = wr_ctrl ? wr_run : run_q;
  assign ien_d      = wr_ctrl ? wr_ien : ien_q;
  assign rate_d     = wr_ctrl ? wr_rate : rate_q;
  assign osc_stop_d = wr_conf ? wr_osc : osc_stop_q;
  // rate is taken as written; changing it while running may misfire once
  assign ack_clear  = wr_ctrl & wr_ack;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= CTRL_RESET[RUN_BIT];
    end else begin
      run_q <= run_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ien_q <= CTRL_RESET[IEN_BIT];
    end else begin
      ien_q <= ien_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_q <= RATE_RESET;
    end else begin
      rate_q <= rate_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_stop_q <= CONF_RESET[OSC_STOP_BIT];
    end else begin
      osc_stop_q <= osc_stop_d;
    end
  end

  // chain counts crystal edges; frozen in stop unless oscillator kept on
  assign chain_active = run_q & (~stop_mode | osc_stop_q);

  always_comb begin
    chain_d = chain_q;
    if (!run_q) begin
      chain_d = '0;
    end else if (chain_active && xtal_rise) begin
      chain_d = chain_q + 1'b1;
    end
  end

  // tick on the tap's rising edge: first after half, then every period
  assign tap_sel = tap_index(rate_q);
  assign tap_now = chain_q[tap_sel];
  assign tick    = run_q & tap_now & ~tap_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chain_q <= '0;
    end else begin
      chain_q <= chain_d;
    end
  end

  // previous tap level; cleared while stopped so restart ticks at half
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tap_prev_q <= 1'b0;
    end else begin
      tap_prev_q <= run_q & tap_now;
    end
  end

  // a tick beats an acknowledge in the same cycle
  always_comb begin
    flag_d = flag_q;
    if (tick) begin
      flag_d = 1'b1;
    end else if (ack_clear) begin
      flag_d = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= CTRL_RESET[FLAG_BIT];
    end else begin
      flag_q <= flag_d;
    end
  end

  // read images; acknowledge always reads zero
  assign ctrl_image = {flag_d, rate_d, 1'b0, ien_d, run_d, 1'b0};
  assign conf_image = {7'h00, osc_stop_d};

  // upper bytes always read zero
  assign ctrl_word = {24'h00_0000, ctrl_image};
  assign conf_word = {24'h00_0000, conf_image};

  // read data built from next values so a write just before is seen
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_ctrl) begin
      rdata_d = ctrl_word;
    end else if (rd_conf) begin
      rdata_d = conf_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // interrupt follows flag and enable in the cycle the flag flop updates
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= flag_d & ien_d;
    end
  end

  // wakeup only when the oscillator is kept running through stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= flag_d & ien_d & stop_mode & osc_stop_q;
    end
  end

  // no wait states and never an error, still served from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      readyout_q <= 1'b1;
    end else begin
      readyout_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resp_q <= 1'b0;
    end else begin
      resp_q <= 1'b0;
    end
  end

  // hsize is not checked: only whole-word transfers reach this slave
  assign hreadyout   = readyout_q;
  assign hresp       = resp_q;
  assign hrdata      = rdata_q;
  assign tick_irq    = irq_q;
  assign stop_wakeup = wake_q;

endmodule

// File: verif/ptt_props.sv
/* checker on the timebase ports
   assumes one hclk domain; bound at the foot */
`timescale 1ns/100ps
module ptt_props
  import ptt_pkg::*;
(
  // bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // power modes and requests
  input wire logic        wait_mode,
  input wire logic        stop_mode,
  input wire logic        tick_irq,
  input wire logic        stop_wakeup
);
  // hready is tied to hreadyout, so the latter stands in for it
  wire  wr_d = hsel && hreadyout && htrans[1] && hwrite
               && haddr[7:0] == CTRL_OFFSET;
  logic wr_q;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) wr_q <= 1'b0;
    else wr_q <= wr_d;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_req; hsel && hreadyout && htrans[1] && !hwrite; endsequence
  sequence ack_no_ien;
    wr_q && hwdata[ACK_BIT] && !hwdata[IEN_BIT] && !wait_mode && !stop_mode;
  endsequence
  irq_after_reset_a:
    assert property (!$past(hresetn) |-> !tick_irq) else $error("irq at reset");
  wait_read_a:
    assert property (rd_req ##0 wait_mode |=> hrdata == 32'h0)
      else $error("read data in wait");
  stop_read_a:
    assert property (rd_req ##0 stop_mode |=> hrdata == 32'h0)
      else $error("read data in stop");
  ien_gates_a:
    assert property (ack_no_ien |=> !tick_irq) else $error("irq not gated");
  flag_holds_a:
    assert property ($fell(tick_irq) |-> $past(wr_q))
      else $error("irq dropped unasked");
  wake_stop_a:
    assert property (stop_wakeup |-> $past(stop_mode))
      else $error("wakeup out of stop");
  bus_okay_a:
    assert property (hreadyout && !hresp) else $error("bus not okay");
  ack_zero_a:
    assert property (!hrdata[ACK_BIT] && hrdata[31:8] == 24'h0)
      else $error("ack bit read high");
endmodule
bind ptt_timebase ptt_props u_props (
  .hclk        (hclk),
  .hresetn     (hresetn),
  .hsel        (hsel),
  .haddr       (haddr),
  .htrans      (htrans),
  .hwrite      (hwrite),
  .hwdata      (hwdata),
  .hreadyout   (hreadyout),
  .hresp       (hresp),
  .hrdata      (hrdata),
  .wait_mode   (wait_mode),
  .stop_mode   (stop_mode),
  .tick_irq    (tick_irq),
  .stop_wakeup (stop_wakeup)
);

// File: verif/tb.sv
/* bench: bus tasks, crystal bursts and tick scenarios
   assumes the checker is bound from its own file */
`timescale 1ns/100ps
module tb
  import ptt_pkg::*;
;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  logic        crystal_clock = 1'b0, wait_mode = 1'b0, stop_mode = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  wire  [31:0] hrdata;
  wire         hready, hreadyout, hresp, tick_irq, stop_wakeup;
  int          n_errors = 0, num_checks = 0;
  int          dv [8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
  assign hready = hreadyout;
  always #25 hclk = ~hclk;
  ptt_timebase DUT (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .hsel          (hsel),
    .haddr         (haddr),
    .htrans        (htrans),
    .hwrite        (hwrite),
    .hsize         (hsize),
    .hwdata        (hwdata),
    .hready        (hready),
    .hreadyout     (hreadyout),
    .hresp         (hresp),
    .hrdata        (hrdata),
    .crystal_clock (crystal_clock),
    .wait_mode     (wait_mode),
    .stop_mode     (stop_mode),
    .tick_irq      (tick_irq),
    .stop_wakeup   (stop_wakeup)
  );
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdy;
    for (int k = 0; k < 20; k++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    n_errors++;
    summarize();
  endtask
  // write d, or read and expect d
  task automatic acc(input logic w, input logic [7:0] d,
                     input logic [7:0] a = 8'h00);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    rdy();
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    rdy();
    if (!w) chk(hrdata, {24'h0, d});
  endtask
  // crystal rests low between bursts so no stray edge sneaks in
  task automatic xt(input int n);
    repeat (n) begin
      crystal_clock <= 1'b1;
      repeat (2) @(posedge hclk);
      crystal_clock <= 1'b0;
      repeat (2) @(posedge hclk);
    end
    repeat (3) @(posedge hclk);
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    acc(1'b0, 8'h00);
    for (int r = 0; r < 8; r++) begin
      acc(1'b1, {1'b0, r[2:0], 4'h6});
      xt(dv[r] / 2 - 1);
      acc(1'b0, {1'b0, r[2:0], 4'h6});
      xt(1);
      acc(1'b0, {1'b1, r[2:0], 4'h6});
      acc(1'b1, {1'b0, r[2:0], 4'h8});
    end
    acc(1'b1, 8'h76);
    xt(4);
    acc(1'b0, 8'hF6);
    chk({31'h0, tick_irq}, 32'h1);
    acc(1'b1, 8'h7E);
    acc(1'b0, 8'h76);
    xt(8);
    acc(1'b0, 8'hF6);
    acc(1'b1, 8'h76);
    acc(1'b0, 8'hF6);
    acc(1'b1, 8'h7E);
    wait_mode <= 1'b1;
    acc(1'b0, 8'h00);
    acc(1'b1, 8'h00);
    xt(8);
    wait_mode <= 1'b0;
    acc(1'b0, 8'hF6);
    acc(1'b1, 8'h7E);
    stop_mode <= 1'b1;
    acc(1'b0, 8'h00);
    xt(8);
    stop_mode <= 1'b0;
    acc(1'b0, 8'h76);
    acc(1'b1, 8'h01, CONF_OFFSET);
    stop_mode <= 1'b1;
    xt(8);
    chk({31'h0, stop_wakeup}, 32'h1);
    stop_mode <= 1'b0;
    acc(1'b1, 8'h08);
    stop_mode <= 1'b1;
    xt(4);
    chk({30'h0, stop_wakeup, tick_irq}, 32'h0);
    stop_mode <= 1'b0;
    acc(1'b0, 8'h00);
    acc(1'b0, 8'h00, 8'h08);
    acc(1'b1, 8'h76);
    xt(4);
    chk({31'h0, tick_irq}, 32'h1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk({31'h0, tick_irq}, 32'h0);
    acc(1'b0, 8'h00);
    acc(1'b0, 8'h00, CONF_OFFSET);
    summarize();
  end
endmodule
